// ---- rtl/ebs_consts.svh ----
// Constants for the external bus strobe control block.
// What this block does
// - Reset returns all outputs to defaults.
// - First fetch after reset uses reset vector.
// - Address latch strobe high marks address phase.
// - Address latch strobe pulses only for external cycles.
// - Code fetch strobe low during external code.
// - Code source captured once at reset release.
// - Captured zero sends every fetch external.
// - Captured one uses internal below limit.
// - After reset release the pin is wait.
// - Wait high stretches the external cycle.
// - Separate active low data read strobe.
// - Bus width captured at release, one selects 16.
// - Separate low byte data write strobe.
`ifndef EBS_CONSTS_SVH
`define EBS_CONSTS_SVH

// Address of the first instruction fetched after reset.
`define EBS_RESET_VECTOR    20'h00000
// First code address that no longer lies in on-chip program memory.
`define EBS_INT_CODE_LIMIT  20'h10000
// Strap values held while reset is asserted.
`define EBS_CODE_SRC_RST    1'b1
`define EBS_BUS16_RST       1'b0
// Strap bit positions in the synchronised pin vector.
`define EBS_PIN_CODE_SRC    0
`define EBS_PIN_BUS_WIDTH   1
// Strobe cycles kept after wait is seen low, covering the data synchroniser.
`define EBS_STROBE_TAIL     2'h2

`endif

// ---- rtl/ebs_pkg.sv ----
// Types shared by the external bus strobe control block.
package ebs_pkg;

    // Kind of access requested by the core.
    typedef enum logic [1:0] {
        EBS_KIND_CODE,
        EBS_KIND_READ,
        EBS_KIND_WRITE
    } ebs_kind_t;

    // Bus sequencer states.
    typedef enum logic [2:0] {
        EBS_IDLE,
        EBS_ADDR,
        EBS_HOLD,
        EBS_STROBE,
        EBS_INT_REQ,
        EBS_INT_DATA
    } ebs_state_t;

endpackage : ebs_pkg

// ---- rtl/ebs_strap_if.sv ----
// Interface carrying captured straps and the synchronised wait level.
`timescale 1ns/1ps
interface ebs_strap_if;
    logic wait_level;   // Synchronised wait input, high stretches a cycle.
    logic code_src;     // Captured code source select.
    logic bus16;        // Captured bus width, high means 16 bits.
    logic straps_valid; // High once the straps have been captured.

    // The strap module produces, the sequencer consumes.
    modport prod (output wait_level, output code_src, output bus16, output straps_valid);
    modport cons (input wait_level, input code_src, input bus16, input straps_valid);
endinterface : ebs_strap_if

// ---- rtl/ebs_strap.sv ----
// Pin synchroniser and reset-release strap capture.
`timescale 1ns/1ps
`include "ebs_consts.svh"
module ebs_strap (
    input  wire logic   ref_clk,
    input  wire logic   rst,
    input  wire logic   code_source_select,
    input  wire logic   bus_width_select,
    ebs_strap_if.prod   strap
);
    logic [1:0] sync1_reg;      // First synchroniser stage, read only by the second.
    logic [1:0] sync2_reg;      // Second synchroniser stage.
    logic       rst_seen_reg;   // High in the first cycle after reset release.
    logic       rst_seen_next;  // Next value of rst_seen_reg.
    logic       code_src_reg;   // Captured code source select.
    logic       code_src_next;  // Next value of code_src_reg.
    logic       bus16_reg;      // Captured bus width select.
    logic       bus16_next;     // Next value of bus16_reg.
    logic       valid_reg;      // Straps captured.
    logic       valid_next;     // Next value of valid_reg.

    // The synchroniser is not reset so it tracks the pins during reset.
    always_ff @(posedge ref_clk)
    begin
        sync1_reg <= {bus_width_select, code_source_select};
        sync2_reg <= sync1_reg;
    end

    // Capture the straps exactly once, in the first cycle after release.
    always_comb
    begin
        rst_seen_next = 1'b0;
        code_src_next = code_src_reg;
        bus16_next    = bus16_reg;
        valid_next    = valid_reg;
        if (rst_seen_reg)
        begin
            code_src_next = sync2_reg[`EBS_PIN_CODE_SRC];
            bus16_next    = sync2_reg[`EBS_PIN_BUS_WIDTH];
            valid_next    = 1'b1;
        end
    end

    // Register the strap state; reset restores the defaults.
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            rst_seen_reg <= 1'b1;
            code_src_reg <= `EBS_CODE_SRC_RST;
            bus16_reg    <= `EBS_BUS16_RST;
            valid_reg    <= 1'b0;
        end
        else
        begin
            rst_seen_reg <= rst_seen_next;
            code_src_reg <= code_src_next;
            bus16_reg    <= bus16_next;
            valid_reg    <= valid_next;
        end
    end

    // After release the same pin only acts as the wait input.
    assign strap.wait_level   = valid_reg & sync2_reg[`EBS_PIN_CODE_SRC];
    assign strap.code_src     = code_src_reg;
    assign strap.bus16        = bus16_reg;
    assign strap.straps_valid = valid_reg;

    // Once captured, the code source never changes again.
    a_strap_stays_put: assert property (@(posedge ref_clk) disable iff (rst)
        valid_reg && $past(valid_reg) |-> $stable(code_src_reg) && $stable(bus16_reg))
        else $error("Strap value changed after capture.");

endmodule : ebs_strap

// ---- rtl/ebs_bus_ctrl.sv ----
// External bus strobe sequencer with code source routing.
`timescale 1ns/1ps
`include "ebs_consts.svh"
module ebs_bus_ctrl (
    input  wire logic              ref_clk,
    input  wire logic              rst,
    input  wire logic              code_source_select,
    input  wire logic              bus_width_select,
    input  wire logic              req_valid,
    input  wire ebs_pkg::ebs_kind_t req_kind,
    input  wire logic [19:0]       req_addr,
    input  wire logic [15:0]       req_wdata,
    output logic                   req_ready,
    output logic                   resp_valid,
    output logic [15:0]            resp_data,
    output logic                   int_code_req,
    output logic [15:0]            int_code_addr,
    input  wire logic [15:0]       int_code_rdata,
    output logic                   ale,
    output logic                   code_fetch_strobe_n,
    output logic                   read_strobe_n,
    output logic                   low_byte_write_strobe_n,
    input  wire logic [15:0]       ad_in,
    output logic [15:0]            ad_out,
    output logic                   ad_oe,
    output logic [3:0]             addr_hi,
    output logic                   bus16
);
    ebs_strap_if strap ();  // Captured straps and wait level.

    // Strap capture and pin synchronisation.
    ebs_strap u_strap (
        .ref_clk            (ref_clk),
        .rst                (rst),
        .code_source_select (code_source_select),
        .bus_width_select   (bus_width_select),
        .strap              (strap.prod)
    );

    ebs_pkg::ebs_state_t state_reg;    // Sequencer state.
    ebs_pkg::ebs_state_t state_next;   // Next sequencer state.
    ebs_pkg::ebs_kind_t  kind_reg;     // Kind of the access in flight.
    ebs_pkg::ebs_kind_t  kind_next;    // Next access kind.
    logic [19:0]         addr_reg;     // Address of the access in flight.
    logic [19:0]         addr_next;    // Next access address.
    logic [15:0]         wdata_reg;    // Write data of the access in flight.
    logic [15:0]         wdata_next;   // Next write data.
    logic                boot_reg;     // Reset vector fetch still owed.
    logic                boot_next;    // Next boot flag.
    logic [1:0]          tail_reg;     // Strobe cycles counted since wait went low.
    logic [1:0]          tail_next;    // Next tail count.
    logic                ale_reg;      // Address latch strobe.
    logic                ale_next;     // Next address latch strobe.
    logic                cfs_n_reg;    // Code fetch strobe, active low.
    logic                cfs_n_next;   // Next code fetch strobe.
    logic                rd_n_reg;     // Data read strobe, active low.
    logic                rd_n_next;    // Next data read strobe.
    logic                wrl_n_reg;    // Low byte write strobe, active low.
    logic                wrl_n_next;   // Next low byte write strobe.
    logic [15:0]         ad_out_reg;   // Value driven on the multiplexed bus.
    logic [15:0]         ad_out_next;  // Next bus drive value.
    logic                ad_oe_reg;    // Bus output enable.
    logic                ad_oe_next;   // Next bus output enable.
    logic                rsp_v_reg;    // Completion pulse.
    logic                rsp_v_next;   // Next completion pulse.
    logic [15:0]         rsp_d_reg;    // Read data returned to the core.
    logic [15:0]         rsp_d_next;   // Next read data.
    logic                int_req_reg;  // On-chip code memory request.
    logic                int_req_next; // Next on-chip request.
    logic [15:0]         ad_s1_reg;    // Bus data, first synchroniser stage.
    logic [15:0]         ad_s2_reg;    // Bus data, second synchroniser stage.
    ebs_pkg::ebs_kind_t  start_kind;   // Kind of the access being started.
    logic [19:0]         start_addr;   // Address of the access being started.

    // Decides whether a fetch is served by on-chip program memory.
    function automatic logic ebs_is_internal(input logic code_src, input ebs_pkg::ebs_kind_t kind,
                                             input logic [19:0] addr);
        ebs_is_internal = code_src && (kind == ebs_pkg::EBS_KIND_CODE)
                          && (addr < `EBS_INT_CODE_LIMIT);
    endfunction : ebs_is_internal

    // Bus data passes two flip-flops before it is captured.
    always_ff @(posedge ref_clk)
    begin
        ad_s1_reg <= ad_in;
        ad_s2_reg <= ad_s1_reg;
    end

    // The owed reset vector fetch goes ahead of any core request.
    assign start_kind = boot_reg ? ebs_pkg::EBS_KIND_CODE : req_kind;
    assign start_addr = boot_reg ? `EBS_RESET_VECTOR : req_addr;
    assign req_ready  = (state_reg == ebs_pkg::EBS_IDLE) && !boot_reg && strap.straps_valid;

    // Next state and strobe values of the sequencer.
    always_comb
    begin
        state_next   = state_reg;
        kind_next    = kind_reg;
        addr_next    = addr_reg;
        wdata_next   = wdata_reg;
        boot_next    = boot_reg;
        tail_next    = tail_reg;
        ale_next     = 1'b0;
        cfs_n_next   = 1'b1;
        rd_n_next    = 1'b1;
        wrl_n_next   = 1'b1;
        ad_out_next  = ad_out_reg;
        ad_oe_next   = 1'b0;
        rsp_v_next   = 1'b0;
        rsp_d_next   = rsp_d_reg;
        int_req_next = 1'b0;
        unique case (state_reg)
            ebs_pkg::EBS_IDLE:
            begin
                // Start only once the straps are known.
                if (strap.straps_valid && (boot_reg || req_valid))
                begin
                    kind_next  = start_kind;
                    addr_next  = start_addr;
                    wdata_next = req_wdata;
                    boot_next  = 1'b0;
                    if (ebs_is_internal(strap.code_src, start_kind, start_addr))
                    begin
                        // On-chip fetch: no external cycle, no address strobe.
                        state_next   = ebs_pkg::EBS_INT_REQ;
                        int_req_next = 1'b1;
                    end
                    else
                    begin
                        // External cycle: address phase with the latch strobe high.
                        state_next  = ebs_pkg::EBS_ADDR;
                        ale_next    = 1'b1;
                        ad_out_next = start_addr[15:0];
                        ad_oe_next  = 1'b1;
                    end
                end
            end
            ebs_pkg::EBS_ADDR:
            begin
                // Latch strobe falls while the address is still held.
                state_next = ebs_pkg::EBS_HOLD;
                ad_oe_next = 1'b1;
            end
            ebs_pkg::EBS_HOLD:
            begin
                // Address phase over: the strobe for this kind goes low.
                state_next = ebs_pkg::EBS_STROBE;
                tail_next  = 2'h0;
                cfs_n_next = (kind_reg != ebs_pkg::EBS_KIND_CODE);
                rd_n_next  = (kind_reg != ebs_pkg::EBS_KIND_READ);
                wrl_n_next = (kind_reg != ebs_pkg::EBS_KIND_WRITE);
                if (kind_reg == ebs_pkg::EBS_KIND_WRITE)
                begin
                    // Eight-bit bus carries only the low byte.
                    ad_out_next = strap.bus16 ? wdata_reg : {8'h00, wdata_reg[7:0]};
                    ad_oe_next  = 1'b1;
                end
            end
            ebs_pkg::EBS_STROBE:
            begin
                cfs_n_next = cfs_n_reg;
                rd_n_next  = rd_n_reg;
                wrl_n_next = wrl_n_reg;
                ad_oe_next = ad_oe_reg;
                if (strap.wait_level)
                begin
                    // Wait high: hold the strobe and restart the tail.
                    tail_next = 2'h0;
                end
                else if (tail_reg == `EBS_STROBE_TAIL)
                begin
                    // Synchronised data now reflects the strobed bus.
                    state_next = ebs_pkg::EBS_IDLE;
                    cfs_n_next = 1'b1;
                    rd_n_next  = 1'b1;
                    wrl_n_next = 1'b1;
                    ad_oe_next = 1'b0;
                    rsp_v_next = 1'b1;
                    rsp_d_next = strap.bus16 ? ad_s2_reg : {8'h00, ad_s2_reg[7:0]};
                end
                else
                begin
                    tail_next = tail_reg + 2'h1;
                end
            end
            ebs_pkg::EBS_INT_REQ:
            begin
                // On-chip memory registers the address this cycle.
                state_next = ebs_pkg::EBS_INT_DATA;
            end
            ebs_pkg::EBS_INT_DATA:
            begin
                // On-chip data is returned without any external strobe.
                state_next = ebs_pkg::EBS_IDLE;
                rsp_v_next = 1'b1;
                rsp_d_next = int_code_rdata;
            end
        endcase
    end

    // Register the sequencer; reset forces every pin to its idle level.
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            state_reg   <= ebs_pkg::EBS_IDLE;
            kind_reg    <= ebs_pkg::EBS_KIND_CODE;
            addr_reg    <= 20'h00000;
            wdata_reg   <= 16'h0000;
            boot_reg    <= 1'b1;
            tail_reg    <= 2'h0;
            ale_reg     <= 1'b0;
            cfs_n_reg   <= 1'b1;
            rd_n_reg    <= 1'b1;
            wrl_n_reg   <= 1'b1;
            ad_out_reg  <= 16'h0000;
            ad_oe_reg   <= 1'b0;
            rsp_v_reg   <= 1'b0;
            rsp_d_reg   <= 16'h0000;
            int_req_reg <= 1'b0;
        end
        else
        begin
            state_reg   <= state_next;
            kind_reg    <= kind_next;
            addr_reg    <= addr_next;
            wdata_reg   <= wdata_next;
            boot_reg    <= boot_next;
            tail_reg    <= tail_next;
            ale_reg     <= ale_next;
            cfs_n_reg   <= cfs_n_next;
            rd_n_reg    <= rd_n_next;
            wrl_n_reg   <= wrl_n_next;
            ad_out_reg  <= ad_out_next;
            ad_oe_reg   <= ad_oe_next;
            rsp_v_reg   <= rsp_v_next;
            rsp_d_reg   <= rsp_d_next;
            int_req_reg <= int_req_next;
        end
    end

    // Outputs all come from registers.
    assign ale                     = ale_reg;
    assign code_fetch_strobe_n     = cfs_n_reg;
    assign read_strobe_n           = rd_n_reg;
    assign low_byte_write_strobe_n = wrl_n_reg;
    assign ad_out                  = ad_out_reg;
    assign ad_oe                   = ad_oe_reg;
    assign addr_hi                 = addr_reg[19:16];
    assign resp_valid              = rsp_v_reg;
    assign resp_data               = rsp_d_reg;
    assign int_code_req            = int_req_reg;
    assign int_code_addr           = addr_reg[15:0];
    assign bus16                   = strap.bus16;

    // A latch strobe lasts one cycle and a strobe follows two cycles later.
    a_ale_then_strobe: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(ale_reg) |=> !ale_reg ##1 (!cfs_n_reg || !rd_n_reg || !wrl_n_reg))
        else $error("Address strobe not followed by a data strobe.");

    // The code fetch strobe is low only for external code cycles.
    a_cfs_code_only: assert property (@(posedge ref_clk) disable iff (rst)
        !cfs_n_reg |-> kind_reg == ebs_pkg::EBS_KIND_CODE && !int_req_reg)
        else $error("Code fetch strobe low outside an external code cycle.");

    // A read strobe falls two cycles after the latch strobe rose.
    a_read_after_ale: assert property (@(posedge ref_clk) disable iff (rst)
        $fell(rd_n_reg) |-> $past(ale_reg, 2) && !ale_reg)
        else $error("Read strobe did not follow an address phase.");

    // A write strobe falls two cycles after the latch strobe rose.
    a_write_after_ale: assert property (@(posedge ref_clk) disable iff (rst)
        $fell(wrl_n_reg) |-> $past(ale_reg, 2) && ad_oe_reg)
        else $error("Write strobe did not follow an address phase.");

    // Wait high keeps the active strobe low in the next cycle.
    a_wait_stretches: assert property (@(posedge ref_clk) disable iff (rst)
        (state_reg == ebs_pkg::EBS_STROBE) && strap.wait_level |=> $stable({cfs_n_reg, rd_n_reg, wrl_n_reg}))
        else $error("Cycle ended while wait was high.");

    // With the code source captured low, on-chip memory is never used.
    a_external_only: assert property (@(posedge ref_clk) disable iff (rst)
        strap.straps_valid && !strap.code_src |-> !int_req_reg)
        else $error("On-chip fetch with external-only code source.");

    // On-chip fetches stay below the memory limit.
    a_internal_limit: assert property (@(posedge ref_clk) disable iff (rst)
        int_req_reg |-> strap.code_src && (addr_reg < `EBS_INT_CODE_LIMIT))
        else $error("On-chip fetch above the memory limit.");

    // The first access after reset is a code fetch from the reset vector.
    a_boot_vector: assert property (@(posedge ref_clk) disable iff (rst)
        $fell(boot_reg) |-> addr_reg == `EBS_RESET_VECTOR && kind_reg == ebs_pkg::EBS_KIND_CODE)
        else $error("First fetch did not use the reset vector.");

endmodule : ebs_bus_ctrl

// ---- bench/ebs_mem_model.sv ----
// Behavioural external memories, address latch and on-chip code memory.
`timescale 1ns/1ps
module ebs_mem_model (
    input  wire logic        ref_clk,
    input  wire logic        ale,
    input  wire logic        code_fetch_strobe_n,
    input  wire logic        read_strobe_n,
    input  wire logic        low_byte_write_strobe_n,
    input  wire logic [15:0] ad_out,
    input  wire logic [3:0]  addr_hi,
    input  wire logic        int_code_req,
    input  wire logic [15:0] int_code_addr,
    output logic      [15:0] ad_in,
    output logic      [15:0] int_code_rdata,
    output logic      [15:0] wr_data
);
    logic [19:0] addr_reg = 20'h00000; // Address held by the external latch.
    logic [15:0] churn    = 16'h0000;  // Changing pattern shown on a released bus.

    // The latch and the memories act on the block's strobes.
    always @(posedge ref_clk)
    begin
        if (ale) addr_reg <= {addr_hi, ad_out};
        if (!low_byte_write_strobe_n) wr_data <= ad_out;
        churn <= ~churn;
        // On-chip memory answers one cycle after a request, then its lines change.
        if (int_code_req) int_code_rdata <= int_code_addr ^ 16'h3c3c;
        else int_code_rdata <= ~int_code_rdata;
    end

    // Memory drives data only while a read strobe is low.
    assign ad_in = (!code_fetch_strobe_n || !read_strobe_n) ? (addr_reg[15:0] ^ 16'h5aa5) : churn;
endmodule : ebs_mem_model

// ---- bench/ebs_bus_ctrl_tb.sv ----
// Self-checking bench for the external bus strobe sequencer.
`timescale 1ns/1ps
module ebs_bus_ctrl_tb;
    logic ref_clk, rst = 1'b1, code_source_select = 1'b1, bus_width_select = 1'b1, req_valid = 1'b0;
    ebs_pkg::ebs_kind_t req_kind = ebs_pkg::EBS_KIND_CODE, cur_kind = ebs_pkg::EBS_KIND_CODE;
    logic [19:0] req_addr = 20'h00000;
    logic [15:0] req_wdata = 16'h0000, resp_data, int_code_addr, int_code_rdata, ad_in, ad_out, wr_data;
    logic req_ready, resp_valid, int_code_req, ale, code_fetch_strobe_n, read_strobe_n;
    logic low_byte_write_strobe_n, ad_oe, bus16;
    logic [3:0] addr_hi;
    logic [2:0] sn, sn_prev = 3'b111; // Strobe levels now and one cycle earlier.
    logic [1:0] ale_hist = 2'b00;     // Address strobe in the two previous cycles.
    int err_count = 0, checks_done = 0, cycles = 0, ale_cnt = 0, wait_left = 0;
    int lat, ales, base;
    logic wait_arm = 1'b0;

    ebs_bus_ctrl i_dut (.ref_clk, .rst, .code_source_select, .bus_width_select, .req_valid, .req_kind,
        .req_addr, .req_wdata, .req_ready, .resp_valid, .resp_data, .int_code_req, .int_code_addr,
        .int_code_rdata, .ale, .code_fetch_strobe_n, .read_strobe_n, .low_byte_write_strobe_n, .ad_in,
        .ad_out, .ad_oe, .addr_hi, .bus16);
    ebs_mem_model i_mem (.ref_clk, .ale, .code_fetch_strobe_n, .read_strobe_n, .low_byte_write_strobe_n,
        .ad_out, .addr_hi, .int_code_req, .int_code_addr, .ad_in, .int_code_rdata, .wr_data);

    // Clock at 200 MHz.
    initial
    begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    // Compares one value and counts the result.
    task automatic chk(input string name, input logic [19:0] seen, input logic [19:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // Prints the counts and the verdict, then ends the run.
    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop

    // Cuts a hung run short.
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_count++;
            report_and_stop();
        end
    end

    // Watches the strobes and drives the wait pin when a stretch is armed.
    always @(negedge ref_clk)
    begin
        sn = {code_fetch_strobe_n, read_strobe_n, low_byte_write_strobe_n};
        if (!rst && sn != 3'b111 && sn_prev == 3'b111) chk("strobe_after_ale", 20'(ale_hist), 20'h2);
        if (sn != 3'b111) chk("strobe_kind", 20'(sn), (cur_kind == ebs_pkg::EBS_KIND_CODE) ? 20'h3 :
            (cur_kind == ebs_pkg::EBS_KIND_READ) ? 20'h5 : 20'h6);
        if (sn != 3'b111) chk("bus_drive", 20'(ad_oe), 20'(cur_kind == ebs_pkg::EBS_KIND_WRITE));
        if (ale) chk("addr_drive", 20'(ad_oe), 20'h1);
        if (int_code_req) chk("int_quiet", {16'h0000, sn, ale}, 20'h0000e);
        if (wait_arm && sn != 3'b111 && sn_prev == 3'b111)
        begin
            wait_arm = 1'b0;
            wait_left = 7;
            code_source_select = 1'b1;
        end
        else if (wait_left > 0)
        begin
            wait_left--;
            code_source_select = (wait_left > 0);
        end
        if (ale) ale_cnt++;
        ale_hist = {ale_hist[0], ale};
        sn_prev = sn;
    end

    // Holds one request until taken, then waits for its completion.
    task automatic access(input ebs_pkg::ebs_kind_t k, input logic [19:0] a, input logic [15:0] wd);
        int n;
        int a0;
        req_kind = k;
        req_addr = a;
        req_wdata = wd;
        cur_kind = k;
        req_valid = 1'b1;
        a0 = ale_cnt;
        n = 0;
        while (req_ready !== 1'b1 && n < 50)
        begin
            @(negedge ref_clk);
            n++;
        end
        @(negedge ref_clk);
        req_valid = 1'b0;
        lat = 1;
        while (resp_valid !== 1'b1 && lat < 60)
        begin
            @(negedge ref_clk);
            lat++;
        end
        ales = ale_cnt - a0;
    endtask : access

    // Resets with given straps, checks quiet outputs, waits for the boot fetch.
    task automatic do_reset(input logic cs, input logic bw);
        int a0;
        rst = 1'b1;
        code_source_select = cs;
        bus_width_select = bw;
        cur_kind = ebs_pkg::EBS_KIND_CODE;
        repeat (3) @(negedge ref_clk);
        chk("reset_outputs", {ale, code_fetch_strobe_n, read_strobe_n, low_byte_write_strobe_n,
            ad_oe, req_ready, resp_valid}, 20'h38);
        a0 = ale_cnt;
        rst = 1'b0;
        lat = 0;
        while (resp_valid !== 1'b1 && lat < 60)
        begin
            @(negedge ref_clk);
            lat++;
        end
        code_source_select = 1'b0;
        ales = ale_cnt - a0;
        chk("bus_width", 20'(bus16), 20'(bw));
        chk("boot_ale", 20'(ales), cs ? 20'h0 : 20'h1);
        chk("boot_data", 20'(resp_data), cs ? 20'h03c3c : 20'h000a5);
    endtask : do_reset

    // Code straps high and a 16-bit bus: routing, strobes, write and wait.
    task automatic run_internal_mode();
        do_reset(1'b1, 1'b1);
        access(ebs_pkg::EBS_KIND_CODE, 20'h00100, 16'h0000);
        chk("int_fetch", {resp_data, 4'(ales)}, 20'h3d3c0);
        chk("int_latency", 20'(lat), 20'h3);
        access(ebs_pkg::EBS_KIND_CODE, 20'h10000, 16'h0000);
        chk("ext_fetch", {resp_data, 4'(ales)}, 20'h5aa51);
        access(ebs_pkg::EBS_KIND_READ, 20'h21234, 16'h0000);
        chk("ext_read", {resp_data, 4'(ales)}, 20'h48911);
        chk("addr_hi", 20'(addr_hi), 20'h00002);
        base = lat;
        access(ebs_pkg::EBS_KIND_WRITE, 20'h00040, 16'hbeef);
        chk("ext_write", {wr_data, 4'(ales)}, 20'hbeef1);
        wait_arm = 1'b1;
        access(ebs_pkg::EBS_KIND_READ, 20'h21234, 16'h0000);
        chk("wait_stretch", 20'(lat > base + 3), 20'h1);
        chk("wait_data", 20'(resp_data), 20'h04891);
        access(ebs_pkg::EBS_KIND_CODE, 20'h00100, 16'h0000);
        chk("strap_kept", 20'(ales), 20'h0);
    endtask : run_internal_mode

    // Code straps low and an 8-bit bus: every fetch leaves the chip.
    task automatic run_external_mode();
        do_reset(1'b0, 1'b0);
        access(ebs_pkg::EBS_KIND_CODE, 20'h00137, 16'h0000);
        chk("ext_only_fetch", {resp_data, 4'(ales)}, 20'h00921);
        access(ebs_pkg::EBS_KIND_WRITE, 20'h00040, 16'hbeef);
        chk("byte_write", 20'(wr_data), 20'h000ef);
    endtask : run_external_mode

    // Main sequence.
    initial
    begin
        @(negedge ref_clk);
        run_internal_mode();
        run_external_mode();
        report_and_stop();
    end
endmodule : ebs_bus_ctrl_tb
